// ==== psr_pkg.sv ====
package psr_pkg;

  // ----------------------------------------------------------------------
  // General register file geometry
  // ----------------------------------------------------------------------
  localparam int          GPR_COUNT     = 16;
  localparam int          GPR_WIDTH     = 32;
  localparam int          GPR_IDX_W     = 4;
  localparam logic [3:0]  GPR_IDX_PROG  = 4'hf;
  localparam logic [3:0]  GPR_IDX_STACK = 4'he;
  localparam logic [3:0]  GPR_IDX_FRAME = 4'hd;
  localparam logic [3:0]  GPR_IDX_ARG   = 4'hc;
  localparam logic [31:0] GPR_RST       = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Status longword field positions
  // ----------------------------------------------------------------------
  localparam int          STAT_COMPAT_BIT  = 31;
  localparam int          STAT_TRACE_PEND  = 30;
  localparam int          STAT_FIRST_DONE  = 27;
  localparam int          STAT_INT_STACK   = 26;
  localparam int          STAT_ACT_MODE_HI = 25;
  localparam int          STAT_ACT_MODE_LO = 24;
  localparam int          STAT_PRI_MODE_HI = 23;
  localparam int          STAT_PRI_MODE_LO = 22;
  localparam int          STAT_LEVEL_HI    = 20;
  localparam int          STAT_LEVEL_LO    = 16;
  localparam int          STAT_BCD_OVF_EN  = 7;
  localparam int          STAT_FLT_UNF_EN  = 6;
  localparam int          STAT_INT_OVF_EN  = 5;
  localparam int          STAT_TRACE_EN    = 4;
  localparam int          STAT_CC_N        = 3;
  localparam int          STAT_CC_Z        = 2;
  localparam int          STAT_CC_V        = 1;
  localparam int          STAT_CC_C        = 0;

  // ----------------------------------------------------------------------
  // Status longword masks and reset value
  // ----------------------------------------------------------------------
  localparam logic [31:0] STAT_IMPL_MASK   = 32'h4fdf_00ff;
  localparam logic [31:0] STAT_WORD_MASK   = 32'h0000_ffff;
  localparam logic [31:0] STAT_RST         = 32'h0000_0000;
  localparam logic [1:0]  STAT_PRIV_MODE   = 2'h0;

endpackage

// ==== psr_gpr_if.sv ====
`timescale 1ns/10ps
interface psr_gpr_if;
  import psr_pkg::*;

  logic [GPR_IDX_W-1:0] rd_a_idx;
  logic [GPR_IDX_W-1:0] rd_b_idx;
  logic [GPR_WIDTH-1:0] rd_a_data;
  logic [GPR_WIDTH-1:0] rd_b_data;
  logic                 wr_en;
  logic [GPR_IDX_W-1:0] wr_idx;
  logic [GPR_WIDTH-1:0] wr_data;
  logic [GPR_WIDTH-1:0] prog_ctr;
  logic [GPR_WIDTH-1:0] stack_ptr;
  logic [GPR_WIDTH-1:0] frame_ptr;
  logic [GPR_WIDTH-1:0] arg_ptr;

  modport owner (
    input  rd_a_idx,
    input  rd_b_idx,
    output rd_a_data,
    output rd_b_data,
    input  wr_en,
    input  wr_idx,
    input  wr_data,
    output prog_ctr,
    output stack_ptr,
    output frame_ptr,
    output arg_ptr
  );

  modport user (
    output rd_a_idx,
    output rd_b_idx,
    input  rd_a_data,
    input  rd_b_data,
    output wr_en,
    output wr_idx,
    output wr_data,
    input  prog_ctr,
    input  stack_ptr,
    input  frame_ptr,
    input  arg_ptr
  );

endinterface

// ==== psr_gpr_file.sv ====
`timescale 1ns/10ps
module psr_gpr_file
  import psr_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_srst,
  psr_gpr_if.owner      gpr
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [GPR_WIDTH-1:0] gpr_reg  [GPR_COUNT];
  logic [GPR_WIDTH-1:0] gpr_next [GPR_COUNT];

  // ----------------------------------------------------------------------
  // Per-entry update
  // ----------------------------------------------------------------------
  // Sixteen entries, each with its own write decode.
  for (genvar g = 0; g < GPR_COUNT; g++) begin : g_entry
    always_comb begin
      gpr_next[g] = gpr_reg[g];
      if (gpr.wr_en && (gpr.wr_idx == GPR_IDX_W'(g))) begin
        gpr_next[g] = gpr.wr_data;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        gpr_reg[g] <= GPR_RST;
      end else begin
        gpr_reg[g] <= gpr_next[g];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------------
  // indexed read ports.
  assign gpr.rd_a_data = gpr_reg[gpr.rd_a_idx];
  assign gpr.rd_b_data = gpr_reg[gpr.rd_b_idx];
  assign gpr.prog_ctr  = gpr_reg[GPR_IDX_PROG];
  assign gpr.stack_ptr = gpr_reg[GPR_IDX_STACK];
  assign gpr.frame_ptr = gpr_reg[GPR_IDX_FRAME];
  assign gpr.arg_ptr   = gpr_reg[GPR_IDX_ARG];

endmodule

// ==== psr_core.sv ====
// Operation
// - Any mode reads and writes all general registers and the status word.
// - Upper status half moves only under privileged move instructions.
// - Sixteen general registers, indices zero to fifteen.
// - Each general register is 32 bits, bit zero least significant.
// - Register fifteen is the program counter.
// - Register fourteen is the stack pointer.
// - Register thirteen is the frame pointer.
// - Register twelve is the argument pointer.
// - Upper status fields sit at their fixed bit positions.
// - Enables at bits seven to four, condition codes at three to zero.
// - Bit seven is plain read/write storage with no hardware effect.
`timescale 1ns/10ps
module psr_core
  import psr_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic [GPR_IDX_W-1:0] i_rd_a_idx,
  input  wire logic [GPR_IDX_W-1:0] i_rd_b_idx,
  input  wire logic                 i_wr_en,
  input  wire logic [GPR_IDX_W-1:0] i_wr_idx,
  input  wire logic [GPR_WIDTH-1:0] i_wr_data,
  input  wire logic                 i_word_wr_en,
  input  wire logic [15:0]          i_word_wr_data,
  input  wire logic                 i_move_to_en,
  input  wire logic [31:0]          i_move_to_data,
  input  wire logic                 i_move_from_en,
  output logic      [GPR_WIDTH-1:0] o_rd_a_data,
  output logic      [GPR_WIDTH-1:0] o_rd_b_data,
  output logic      [31:0]          o_status,
  output logic      [15:0]          o_status_word,
  output logic      [31:0]          o_move_from_data,
  output logic                      o_move_from_valid,
  output logic                      o_priv_fault,
  output logic      [GPR_WIDTH-1:0] o_program_counter,
  output logic      [GPR_WIDTH-1:0] o_stack_pointer,
  output logic      [GPR_WIDTH-1:0] o_frame_pointer,
  output logic      [GPR_WIDTH-1:0] o_argument_pointer,
  output logic      [1:0]           o_active_access_mode,
  output logic      [4:0]           o_interrupt_priority_level
);

  // ----------------------------------------------------------------------
  // General register file
  // ----------------------------------------------------------------------
  psr_gpr_if gpr_bus ();

  assign gpr_bus.rd_a_idx = i_rd_a_idx;
  assign gpr_bus.rd_b_idx = i_rd_b_idx;
  assign gpr_bus.wr_en    = i_wr_en;
  assign gpr_bus.wr_idx   = i_wr_idx;
  assign gpr_bus.wr_data  = i_wr_data;

  psr_gpr_file u_gpr (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .gpr    (gpr_bus)
  );

  // ----------------------------------------------------------------------
  // Status longword state
  // ----------------------------------------------------------------------
  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic        privileged;

  // Privilege is judged from the mode held before this cycle's update, so
  // a move that lowers the privilege still completes in the same cycle.
  assign privileged = (stat_reg[STAT_ACT_MODE_HI:STAT_ACT_MODE_LO]
                       == STAT_PRIV_MODE);

  // The word write lands after the privileged move, so when both arrive
  // together the low half follows the word write.
  always_comb begin
    stat_next = stat_reg;
    if (i_move_to_en && privileged) begin
      stat_next = i_move_to_data;
    end
    if (i_word_wr_en) begin
      stat_next = (stat_next & ~STAT_WORD_MASK) | {16'h0000, i_word_wr_data};
    end
    stat_next = stat_next & STAT_IMPL_MASK;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stat_reg <= STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  logic [GPR_WIDTH-1:0] rd_a_reg;
  logic [GPR_WIDTH-1:0] rd_a_next;
  logic [GPR_WIDTH-1:0] rd_b_reg;
  logic [GPR_WIDTH-1:0] rd_b_next;
  logic [31:0]          mf_data_reg;
  logic [31:0]          mf_data_next;
  logic                 mf_valid_reg;
  logic                 mf_valid_next;
  logic                 fault_reg;
  logic                 fault_next;
  logic [GPR_WIDTH-1:0] prog_reg;
  logic [GPR_WIDTH-1:0] stack_reg;
  logic [GPR_WIDTH-1:0] frame_reg;
  logic [GPR_WIDTH-1:0] arg_reg;

  // Read data and the move-from answer are registered, one cycle behind
  // the request; a refused move raises a one-cycle fault pulse instead.
  always_comb begin
    rd_a_next     = gpr_bus.rd_a_data;
    rd_b_next     = gpr_bus.rd_b_data;
    mf_data_next  = mf_data_reg;
    mf_valid_next = 1'b0;
    fault_next    = 1'b0;
    if (i_move_from_en) begin
      if (privileged) begin
        mf_data_next  = stat_reg;
        mf_valid_next = 1'b1;
      end else begin
        fault_next    = 1'b1;
      end
    end
    if (i_move_to_en && !privileged) begin
      fault_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_a_reg     <= GPR_RST;
      rd_b_reg     <= GPR_RST;
      mf_data_reg  <= STAT_RST;
      mf_valid_reg <= 1'b0;
      fault_reg    <= 1'b0;
      prog_reg     <= GPR_RST;
      stack_reg    <= GPR_RST;
      frame_reg    <= GPR_RST;
      arg_reg      <= GPR_RST;
    end else begin
      rd_a_reg     <= rd_a_next;
      rd_b_reg     <= rd_b_next;
      mf_data_reg  <= mf_data_next;
      mf_valid_reg <= mf_valid_next;
      fault_reg    <= fault_next;
      prog_reg     <= gpr_bus.prog_ctr;
      stack_reg    <= gpr_bus.stack_ptr;
      frame_reg    <= gpr_bus.frame_ptr;
      arg_reg      <= gpr_bus.arg_ptr;
    end
  end

  // ----------------------------------------------------------------------
  // Port assignments
  // ----------------------------------------------------------------------
  assign o_rd_a_data       = rd_a_reg;
  assign o_rd_b_data       = rd_b_reg;
  assign o_move_from_data  = mf_data_reg;
  assign o_move_from_valid = mf_valid_reg;
  assign o_priv_fault      = fault_reg;
  assign o_program_counter  = prog_reg;
  assign o_stack_pointer    = stack_reg;
  assign o_frame_pointer    = frame_reg;
  assign o_argument_pointer = arg_reg;
  assign o_status                   = stat_reg;
  assign o_status_word              = stat_reg[15:0];
  assign o_active_access_mode       =
    stat_reg[STAT_ACT_MODE_HI:STAT_ACT_MODE_LO];
  assign o_interrupt_priority_level = stat_reg[STAT_LEVEL_HI:STAT_LEVEL_LO];

endmodule

// ==== psr_core_props.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Port checker for the processor state registers
// ----------------------------------------------------------------------
module psr_core_props
  import psr_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_wr_en,
  input wire logic [3:0]  i_wr_idx,
  input wire logic [31:0] i_wr_data,
  input wire logic [3:0]  i_rd_a_idx,
  input wire logic        i_word_wr_en,
  input wire logic [15:0] i_word_wr_data,
  input wire logic        i_move_to_en,
  input wire logic [31:0] i_move_to_data,
  input wire logic        i_move_from_en,
  input wire logic [31:0] o_rd_a_data,
  input wire logic [31:0] o_status,
  input wire logic [15:0] o_status_word,
  input wire logic [31:0] o_move_from_data,
  input wire logic        o_move_from_valid,
  input wire logic        o_priv_fault,
  input wire logic [31:0] o_program_counter,
  input wire logic [1:0]  o_active_access_mode,
  input wire logic [4:0]  o_interrupt_priority_level
);
  // Privilege is judged on the mode shown before the edge.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_reserved_bits_zero: assert property (
    (o_status & ~STAT_IMPL_MASK) == 32'h0)
    else $error("status longword reserved bit set");
  chk_compat_never_set: assert property (
    !o_status[STAT_COMPAT_BIT])
    else $error("compatibility bit set");
  chk_word_mirror: assert property (
    o_status_word == o_status[15:0])
    else $error("status word differs from longword");
  chk_word_write: assert property (
    i_word_wr_en && !i_move_to_en |=>
    o_status[15:0] == ($past(i_word_wr_data) & 16'h00ff))
    else $error("status word write wrong");
  chk_move_to_ok: assert property (
    i_move_to_en && !i_word_wr_en && o_active_access_mode == 2'h0 |=>
    o_status == ($past(i_move_to_data) & STAT_IMPL_MASK))
    else $error("privileged longword write wrong");
  chk_move_to_refused: assert property (
    i_move_to_en && o_active_access_mode != 2'h0 && !i_word_wr_en |=>
    o_priv_fault && $stable(o_status))
    else $error("unprivileged longword write not refused");
  chk_move_from_ok: assert property (
    i_move_from_en && o_active_access_mode == 2'h0 |=>
    o_move_from_valid && o_move_from_data == $past(o_status))
    else $error("privileged longword read wrong");
  chk_move_from_refused: assert property (
    i_move_from_en && o_active_access_mode != 2'h0 |=>
    o_priv_fault && !o_move_from_valid && $stable(o_move_from_data))
    else $error("unprivileged longword read not refused");
  chk_fault_quiet: assert property (
    !i_move_to_en && !i_move_from_en |=> !o_priv_fault)
    else $error("fault raised without a privileged request");
  chk_field_slices: assert property (
    o_active_access_mode == o_status[25:24] &&
    o_interrupt_priority_level == o_status[20:16])
    else $error("mode or level slice wrong");
  chk_gpr_read_back: assert property (
    i_wr_en ##1 i_rd_a_idx == $past(i_wr_idx) |=>
    o_rd_a_data == $past(i_wr_data, 2))
    else $error("register read back wrong");
  chk_pc_follows: assert property (
    i_wr_en && i_wr_idx == GPR_IDX_PROG |=> ##1
    o_program_counter == $past(i_wr_data, 2))
    else $error("program counter copy wrong");
endmodule

// ==== psr_core_tb.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Testbench for the processor state registers
// ----------------------------------------------------------------------
module psr_core_tb;
  import psr_pkg::*;
  logic        i_clk, i_srst, i_wr_en, i_word_wr_en, pf, mv;
  logic        i_move_to_en, i_move_from_en, o_move_from_valid;
  logic        o_priv_fault;
  logic [3:0]  i_rd_a_idx, i_rd_b_idx, i_wr_idx;
  logic [15:0] i_word_wr_data, o_status_word;
  logic [31:0] i_wr_data, i_move_to_data, o_rd_a_data, o_rd_b_data;
  logic [31:0] o_status, o_move_from_data, o_program_counter;
  logic [31:0] o_stack_pointer, o_frame_pointer, o_argument_pointer;
  logic [1:0]  o_active_access_mode;
  logic [4:0]  o_interrupt_priority_level;
  int          mismatches, checks;

  psr_core dut (.*);

  // Clock at 40 MHz.
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Inputs always move 1 ns after the edge, away from sampling.
  task step;
    @(posedge i_clk);
    #1;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task complete_run;
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] val(input int i);
    return {i[3:0], 24'h5ac3e1, ~i[3:0]};
  endfunction

  // One write pulse, read port A pointed at the same index.
  task wr(input logic [3:0] i, input logic [31:0] d);
    i_wr_en = 1'b1;
    i_wr_idx = i;
    i_wr_data = d;
    i_rd_a_idx = i;
    step;
    i_wr_en = 1'b0;
    step;
  endtask

  // Status access; one-cycle answers are latched before the idle cycle.
  task op(input logic w, input logic [15:0] wd, input logic t,
          input logic [31:0] td, input logic f);
    i_word_wr_en = w;
    i_word_wr_data = wd;
    i_move_to_en = t;
    i_move_to_data = td;
    i_move_from_en = f;
    step;
    pf = o_priv_fault;
    mv = o_move_from_valid;
    {i_word_wr_en, i_move_to_en, i_move_from_en} = 3'h0;
    step;
  endtask

  initial begin
    {i_srst, i_wr_en, i_word_wr_en, i_move_to_en} = 4'h8;
    {i_move_from_en, i_rd_a_idx, i_rd_b_idx, i_wr_idx} = 13'h0000;
    {i_word_wr_data, i_wr_data, i_move_to_data} = 80'h0;
    repeat (8) step;
    i_srst = 1'b0;
    step;
    chk("status reset", 32'h00000000, o_status);
    for (int i = 0; i < 16; i++) wr(4'(i), val(i));
    for (int i = 0; i < 16; i++) begin
      i_rd_a_idx = 4'(i);
      i_rd_b_idx = 4'(15 - i);
      step;
      chk("read a", val(i), o_rd_a_data);
      chk("read b", val(15 - i), o_rd_b_data);
    end
    chk("pc", val(15), o_program_counter);
    chk("sp", val(14), o_stack_pointer);
    chk("fp", val(13), o_frame_pointer);
    chk("ap", val(12), o_argument_pointer);
    // Both writes together: word write wins the low half.
    op(1'b1, 16'hff3c, 1'b1, 32'h00000001, 1'b0);
    chk("status both", 32'h0000003c, o_status);
    chk("word both", 32'h003c, {16'h0, o_status_word});
    op(1'b0, 16'h0, 1'b1, 32'h00520080, 1'b0);
    chk("status fields", 32'h00520080, o_status);
    chk("move no fault", 32'h0, {31'h0, pf});
    op(1'b0, 16'h0, 1'b0, 32'h0, 1'b1);
    chk("read valid", 32'h1, {31'h0, mv});
    chk("read no fault", 32'h0, {31'h0, pf});
    chk("read data", 32'h00520080, o_move_from_data);
    op(1'b0, 16'h0, 1'b1, 32'hffffffff, 1'b0);
    chk("status all ones", 32'h4fdf00ff, o_status);
    chk("mode", 32'h3, {30'h0, o_active_access_mode});
    chk("level", 32'h1f, {27'h0, o_interrupt_priority_level});
    op(1'b1, 16'h005a, 1'b0, 32'h0, 1'b0);
    chk("word user", 32'h4fdf005a, o_status);
    chk("word low", 32'h005a, {16'h0, o_status_word});
    op(1'b0, 16'h0, 1'b1, 32'h0, 1'b0);
    chk("move refused", 32'h4fdf005a, o_status);
    chk("fault", 32'h1, {31'h0, pf});
    op(1'b0, 16'h0, 1'b0, 32'h0, 1'b1);
    chk("read refused", 32'h0, {31'h0, mv});
    chk("read fault", 32'h1, {31'h0, pf});
    chk("read held", 32'h00520080, o_move_from_data);
    // A reset in mid-run clears everything again.
    i_srst = 1'b1;
    i_rd_a_idx = 4'hf;
    step;
    i_srst = 1'b0;
    step;
    chk("status again", 32'h0, o_status);
    chk("r15 again", 32'h0, o_rd_a_data);
    chk("pc again", 32'h0, o_program_counter);
    complete_run;
  end
endmodule

bind psr_core psr_core_props chk_props (.*);
